// [include/ldi_pkg.sv]
// Shared constants for the memory-side initialization state tracker
package ldi_pkg;
  // Clock period in picoseconds (20 MHz)
  localparam int CLK_PERIOD_PS = 50000;
  // Times as printed
  localparam int POST_RESET_WAIT_US = 1;
  localparam int AUTO_INIT_MAX_TIME_US = 10;
  localparam int INITIAL_CAL_TIME_US = 1;
  localparam int AUTO_INIT_MIN_NS = 1000;
  // Derived cycle counts: least times round up, longest round down
  localparam int POST_RESET_WAIT_CYC = (POST_RESET_WAIT_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int AUTO_INIT_MAX_CYC = (AUTO_INIT_MAX_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int INITIAL_CAL_CYC = (INITIAL_CAL_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  // Internal auto-initialization duration, below the maximum
  localparam int AUTO_INIT_RUN_CYC = (AUTO_INIT_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  // Avalon register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MR0 = 4'h8;
  // Control bit positions
  localparam int CTRL_TRAIN_POS = 0;
  localparam int CTRL_ODT_POS = 1;
  // Status bit positions
  localparam int ST_IDLE_POS = 0;
  localparam int ST_READY_POS = 1;
  localparam int ST_TRAIN_POS = 2;
  localparam int ST_BANKS_POS = 3;
  localparam int ST_HIZ_POS = 4;
  localparam int ST_STATE_POS = 8;
  // Reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Mode register addresses and operand codes used by the sequence
  localparam logic [7:0] MA_DEV_INFO = 8'h00;
  localparam logic [7:0] MA_CAL = 8'h0A;
  localparam logic [7:0] MA_CA_TRAIN = 8'h29;
  localparam logic [7:0] MA_RESET = 8'h3F;
  localparam logic [7:0] CAL_INIT_CODE = 8'hFF;
  localparam logic [7:0] TRAIN_EXIT_CODE = 8'hA8;
  // Auto-init status bit in mode register 0
  localparam int AUTO_INIT_STATUS_POS = 0;

  typedef enum logic [2:0] {
    ST_POWERED = 3'h0,
    ST_NOP_PHASE = 3'h1,
    ST_RESET_WAIT = 3'h2,
    ST_AUTO_INIT = 3'h3,
    ST_IDLE = 3'h4,
    ST_CA_TRAIN = 3'h5,
    ST_CAL = 3'h6,
    ST_READY = 3'h7
  } ldi_state_type;
endpackage

// [logic/ldi_sync.sv]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ldi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// [logic/ldi_core.sv]
// Memory-side initialization sequencer with mode-register decode and status registers
`timescale 1ns/1ps
`default_nettype none
module ldi_core
  import ldi_pkg::*;
#(
  parameter int RUN_CYC = AUTO_INIT_RUN_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Memory pins, sampled asynchronously
  input wire logic cke_pin,
  input wire logic mem_clk_pin,
  input wire logic odt_pin,
  // Decoded command from the CA bus, on the memory clock
  input wire logic cmd_mrw,
  input wire logic cmd_mrr,
  input wire logic [7:0] cmd_ma,
  input wire logic [7:0] cmd_op,
  // Mode-register read answer
  output logic [7:0] mrr_data,
  output logic mrr_data_oe,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // Auto-init must end inside its maximum, or the run would be cut short at the maximum
  if (RUN_CYC < 1 || RUN_CYC > AUTO_INIT_MAX_CYC) begin : g_bad_run
    $error("RUN_CYC out of range");
  end

  logic [3:0] sync_out;
  logic cke_s, clk_s, mrw_s, mrr_s;
  ldi_sync #(.WIDTH(4)) u_sync (
    .clock(clock),
    .rst(rst),
    .d({cke_pin, mem_clk_pin, cmd_mrw, cmd_mrr}),
    .q(sync_out)
  );
  assign {cke_s, clk_s, mrw_s, mrr_s} = sync_out;

  // Command is sampled at the rising memory-clock edge seen in our domain
  logic clk_d_r;
  logic [7:0] ma_s, op_s;
  logic [15:0] ca_sync_out;
  // Address and operand are set with the strobe and held across the edge,
  // so a plain two-flop path per bit has settled by the time the edge is seen
  ldi_sync #(.WIDTH(16)) u_ca_sync (
    .clock(clock),
    .rst(rst),
    .d({cmd_ma, cmd_op}),
    .q(ca_sync_out)
  );
  assign {ma_s, op_s} = ca_sync_out;
  wire clk_rise = clk_s & ~clk_d_r;
  wire mrw_ev = clk_rise & mrw_s & cke_s;
  wire mrr_ev = clk_rise & mrr_s & cke_s;
  wire is_reset = mrw_ev & (ma_s == MA_RESET);
  wire is_cal = mrw_ev & (ma_s == MA_CAL);
  wire is_train = mrw_ev & (ma_s == MA_CA_TRAIN);

  ldi_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic cke_seen_r, auto_busy_r, auto_busy_nxt;
  logic [1:0] ctrl_r;
  logic odt_lock_r, odt_viol_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    auto_busy_nxt = auto_busy_r;
    case (state_r)
      ST_POWERED: begin
        cnt_nxt = '0;
        if (cke_s) begin
          state_nxt = ST_NOP_PHASE;
        end
      end
      ST_NOP_PHASE: begin
        cnt_nxt = '0;
      end
      ST_RESET_WAIT: begin
        if (cnt_r >= CNT_W'(POST_RESET_WAIT_CYC - 1)) begin
          // Auto-init times its own run from zero
          state_nxt = ST_AUTO_INIT;
          cnt_nxt = '0;
        end
      end
      ST_AUTO_INIT: begin
        // Finish early, clear status, and never exceed the maximum
        if (cnt_r >= CNT_W'(RUN_CYC - 1)) begin
          auto_busy_nxt = 1'b0;
        end
        if (!auto_busy_r || cnt_r >= CNT_W'(AUTO_INIT_MAX_CYC - 1)) begin
          state_nxt = ST_IDLE;
          auto_busy_nxt = 1'b0;
        end
      end
      ST_IDLE: begin
        cnt_nxt = '0;
        // Training can only be entered from idle
        if (is_train && ctrl_r[CTRL_TRAIN_POS]) begin
          state_nxt = ST_CA_TRAIN;
        end else if (is_cal) begin
          state_nxt = ST_CAL;
        end
      end
      ST_CA_TRAIN: begin
        cnt_nxt = '0;
        // No automatic exit: only an exit write returns to idle
        if (is_train && op_s == TRAIN_EXIT_CODE) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_CAL: begin
        if (cnt_r >= CNT_W'(INITIAL_CAL_CYC - 1)) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        cnt_nxt = '0;
      end
      default: begin
        state_nxt = ST_POWERED;
      end
    endcase
    // A reset write restarts from the reset step in every state except ST_POWERED
    if (is_reset && state_r != ST_POWERED) begin
      state_nxt = ST_RESET_WAIT;
      cnt_nxt = '0;
      auto_busy_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_POWERED;
      cnt_r <= '0;
      auto_busy_r <= 1'b1;
      clk_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      auto_busy_r <= auto_busy_nxt;
      clk_d_r <= clk_s;
    end
  end

  // Termination input must stay static from clock-enable until calibration ends
  logic odt_s, odt_ref_r;
  ldi_sync #(.WIDTH(1)) u_odt_sync (
    .clock(clock),
    .rst(rst),
    .d(odt_pin),
    .q(odt_s)
  );
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cke_seen_r <= 1'b0;
      odt_lock_r <= 1'b0;
      odt_ref_r <= 1'b0;
      odt_viol_r <= 1'b0;
    end else begin
      if (cke_s && !cke_seen_r) begin
        cke_seen_r <= 1'b1;
        odt_lock_r <= 1'b1;
        odt_ref_r <= odt_s;
      end else if (state_r == ST_READY) begin
        odt_lock_r <= 1'b0;
      end
      if (odt_lock_r && odt_s != odt_ref_r) begin
        odt_viol_r <= 1'b1;
      end
    end
  end

  // Mode register 0 reads return auto-init status in bit 0
  logic [7:0] mr0_val;
  always_comb begin
    mr0_val = 8'h00;
    mr0_val[AUTO_INIT_STATUS_POS] = auto_busy_r;
  end
  // Reads accepted only after the post-reset wait and never during CA training
  wire rd_ok = mrr_ev && (ma_s == MA_DEV_INFO)
    && state_r != ST_POWERED && state_r != ST_NOP_PHASE && state_r != ST_RESET_WAIT
    && state_r != ST_CA_TRAIN;
  logic [7:0] mrr_data_r;
  logic mrr_oe_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mrr_data_r <= 8'h00;
      mrr_oe_r <= 1'b0;
    end else begin
      mrr_data_r <= rd_ok ? mr0_val : mrr_data_r;
      mrr_oe_r <= rd_ok & cke_s;
    end
  end
  assign mrr_data = mrr_data_r;
  // High impedance whenever clock-enable is low
  assign mrr_data_oe = mrr_oe_r & cke_s;

  // Avalon-MM registers: one wait state on reads, writes take effect at once
  logic rd_pend_r;
  logic [31:0] rdata_r;
  wire sel_ctrl = avs_address == ADDR_CTRL;
  wire sel_status = avs_address == ADDR_STATUS;
  wire sel_mr0 = avs_address == ADDR_MR0;
  // Banks reported precharged whenever idle
  wire banks_pre = state_r == ST_IDLE || state_r == ST_READY;
  wire [31:0] status_word = {20'h00000, 1'b0, state_r, 3'h0, ~cke_s, banks_pre,
    state_r == ST_CA_TRAIN, state_r == ST_READY, state_r == ST_IDLE};
  wire [31:0] rd_mux = sel_ctrl ? {29'h0, odt_viol_r, ctrl_r} :
    sel_status ? status_word :
    sel_mr0 ? {24'h000000, mr0_val} : 32'h00000000;
  assign avs_waitrequest = avs_read & ~rd_pend_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      rdata_r <= 32'h00000000;
      ctrl_r <= CTRL_RESET;
    end else begin
      rd_pend_r <= avs_read & ~rd_pend_r;
      if (avs_read && !rd_pend_r) begin
        rdata_r <= rd_mux;
      end
      if (avs_write && sel_ctrl) begin
        ctrl_r <= avs_writedata[1:0];
      end
    end
  end
endmodule
`default_nettype wire

// [dv/ldi_core_props.sv]
// Port assertions for the init tracker
`timescale 1ns/1ps
`default_nettype none
module ldi_core_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire logic cke_pin,
  input wire logic [7:0] mrr_data,
  input wire logic mrr_data_oe,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_read_start;
    $rose(avs_read) ##0 avs_waitrequest;
  endsequence
  sequence s_read_answer;
    !avs_waitrequest && avs_read;
  endsequence
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  a_idle_nowait: assert property (!avs_read |-> !avs_waitrequest) else $error("idle stall");
  a_read_start: assert property ($rose(avs_read) |-> s_read_start) else $error("read not held");
  a_read_answer: assert property (s_read_start |=> s_read_answer) else $error("read late");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata)) else $error("data moved");
  a_oe_single: assert property (mrr_data_oe |=> !mrr_data_oe) else $error("oe too long");
  a_oe_cke_low: assert property (!cke_pin [*6] |-> !mrr_data_oe) else $error("oe with cke low");
  a_mr0_source: assert property ($changed(mrr_data) |-> ##[0:1]
    (mrr_data_oe || $past(mrr_data_oe))) else $error("mr0 changed without read");
endmodule
bind ldi_core ldi_core_props i_props (.clock(clock), .rst(rst), .cke_pin(cke_pin),
  .mrr_data(mrr_data), .mrr_data_oe(mrr_data_oe), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// [dv/ldi_ctrl_model.sv]
// Controller-side model driving the memory pins
`timescale 1ns/1ps
`default_nettype none
module ldi_ctrl_model (
  // Memory pins
  output logic cke_pin,
  output logic mem_clk_pin,
  output logic odt_pin,
  // Decoded command
  output logic cmd_mrw,
  output logic cmd_mrr,
  output logic [7:0] cmd_ma,
  output logic [7:0] cmd_op
);
  // Clock runs free: it must be stable before clock-enable rises
  // Link period is fixed by the bench; boot read timing is the controller's duty
  initial begin
    {cke_pin, odt_pin, cmd_mrw, cmd_mrr, cmd_ma, cmd_op} = '0;
    mem_clk_pin = 1'b0;
    #7;
    forever #200 mem_clk_pin = ~mem_clk_pin;
  end
  task power_up();
    #100;
    repeat (6) @(posedge mem_clk_pin);
    cke_pin <= 1'b1;
    repeat (501) @(posedge mem_clk_pin);
  endtask
  task send(input logic wr, input logic [7:0] ma, input logic [7:0] op);
    @(negedge mem_clk_pin);
    cmd_mrw <= wr;
    cmd_mrr <= !wr;
    cmd_ma <= ma;
    cmd_op <= op;
    @(negedge mem_clk_pin);
    cmd_mrw <= 1'b0;
    cmd_mrr <= 1'b0;
    // Released lines show the inverse so stale values never look valid
    cmd_ma <= ~ma;
    cmd_op <= ~op;
  endtask
  task power_down();
    @(posedge mem_clk_pin);
    cke_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/ldi_core_tb_top.sv]
// Self-checking bench for the init tracker
`timescale 1ns/1ps
`default_nettype none
module ldi_core_tb_top;
  import ldi_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cke_pin, mem_clk_pin, odt_pin, cmd_mrw, cmd_mrr, mrr_data_oe, avs_waitrequest;
  logic [7:0] cmd_ma, cmd_op, mrr_data;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [15:0] rnd = 16'h4ADA;
  logic [31:0] exp_q[$], mask_q[$];
  int err_count = 0;
  int tests_run = 0;
  int i;
  int oe_seen = 0;
  always #25 clock = ~clock;
  ldi_ctrl_model i_ldi_ctrl_model (.cke_pin(cke_pin), .mem_clk_pin(mem_clk_pin),
    .odt_pin(odt_pin), .cmd_mrw(cmd_mrw), .cmd_mrr(cmd_mrr), .cmd_ma(cmd_ma), .cmd_op(cmd_op));
  ldi_core i_ldi_core (.clock(clock), .rst(rst), .cke_pin(cke_pin), .mem_clk_pin(mem_clk_pin),
    .odt_pin(odt_pin), .cmd_mrw(cmd_mrw), .cmd_mrr(cmd_mrr), .cmd_ma(cmd_ma), .cmd_op(cmd_op),
    .mrr_data(mrr_data), .mrr_data_oe(mrr_data_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Reads leave their masked expectation in the queue
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d,
    input logic [31:0] m);
    @(posedge clock);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    if (rd) begin
      exp_q.push_back(d);
      mask_q.push_back(m);
    end
    @(posedge clock);
    while (avs_waitrequest) @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  always @(posedge clock) begin
    if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
      chk("readdata", exp_q.pop_front(), avs_readdata & mask_q.pop_front());
    end
  end
  // Each accepted mode-register read drives the answer for exactly one cycle
  always @(posedge clock) begin
    if (mrr_data_oe) begin
      oe_seen++;
    end
  end
  task automatic st(input ldi_state_type s);
    logic [31:0] e;
    e = 32'h0;
    e[ST_STATE_POS +: 3] = s;
    e[ST_IDLE_POS] = (s == ST_IDLE);
    e[ST_READY_POS] = (s == ST_READY);
    e[ST_TRAIN_POS] = (s == ST_CA_TRAIN);
    e[ST_BANKS_POS] = (s == ST_IDLE || s == ST_READY);
    e[ST_HIZ_POS] = !cke_pin;
    repeat (6) @(posedge clock);
    bus(1'b1, ADDR_STATUS, e, 32'h71F);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_count++;
    results();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rnd = lfsr(rnd);
    bus(1'b0, ADDR_STATUS, {rnd, rnd}, 32'h0);
    st(ST_POWERED);
    bus(1'b1, ADDR_CTRL, 32'h0, 32'h3);
    bus(1'b0, 4'hC, {rnd, rnd}, 32'h0);
    bus(1'b1, 4'hC, 32'h0, 32'hFFFFFFFF);
    bus(1'b0, ADDR_CTRL, 32'h1, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h1, 32'h7);
    $display("registers done");
    i_ldi_ctrl_model.power_up();
    st(ST_NOP_PHASE);
    rnd = lfsr(rnd);
    i_ldi_ctrl_model.send(1'b1, MA_RESET, rnd[7:0]);
    st(ST_RESET_WAIT);
    repeat (3) @(posedge mem_clk_pin);
    i = 0;
    do begin
      i_ldi_ctrl_model.send(1'b0, MA_DEV_INFO, 8'h00);
      repeat (8) @(posedge clock);
      i++;
    end while (i < 10 && mrr_data[AUTO_INIT_STATUS_POS] !== 1'b0);
    chk("mrr_data", 32'h0, {24'h000000, mrr_data});
    chk("mrr_oe_pulses", i, oe_seen);
    bus(1'b1, ADDR_MR0, 32'h0, 32'h1);
    st(ST_IDLE);
    $display("auto-init done");
    rnd = lfsr(rnd);
    i_ldi_ctrl_model.send(1'b1, MA_CA_TRAIN, {rnd[7:1], 1'b1});
    st(ST_CA_TRAIN);
    i_ldi_ctrl_model.send(1'b1, MA_CA_TRAIN, TRAIN_EXIT_CODE);
    st(ST_IDLE);
    i_ldi_ctrl_model.send(1'b1, MA_CAL, CAL_INIT_CODE);
    st(ST_CAL);
    repeat (INITIAL_CAL_CYC) @(posedge clock);
    for (i = 1; i < 4; i++) i_ldi_ctrl_model.send(1'b1, 8'(i), 8'h00);
    st(ST_READY);
    bus(1'b1, ADDR_CTRL, 32'h1, 32'h7);
    $display("training and calibration done");
    rnd = lfsr(rnd);
    i_ldi_ctrl_model.send(1'b1, MA_RESET, rnd[7:0]);
    st(ST_RESET_WAIT);
    i_ldi_ctrl_model.power_down();
    repeat (6) @(posedge clock);
    bus(1'b1, ADDR_STATUS, 32'h10, 32'h10);
    $display("restart and power-down done");
    results();
  end
endmodule
`default_nettype wire
